// *** verilog/dcmd_decoder.sv ***
// Memory map decoder for one DSP subsystem core
// What this block does
// - Program 0060-7FFF of pages 0-3: dual RAM if overlay, else external.
// - Data 8000-FFFF: single RAM if data-RAM enable, else external.
// - Page 0 program 8000-DFFF: shared block 0, read and write.
// - Page 0 F800-FFFF selects boot ROM while enabled; enabled after reset.
// - Boot ROM disabled: E000 upward becomes shared RAM.
// - Shared blocks 0,1 owned by A; 2,3 owned by B; both reach all.
// - Local dual and single RAM reachable only from own core.
// - Non-MP mode: beyond on-chip memory, upper half of pages above 3 goes external.
// - Non-MP mode: pages 8-127 alias onto pages 4-7.
// - MP mode: upper half of pages 0-3 is external.
// - MP mode: pages 4-127 alias onto pages 0-3.
// - External access completes only while external enable is high.
// - I/O space is one 64K page, always external.
// - Blocks are 8K words; block index is address bits above 12.
// - External access while disabled: write dropped, read undefined.
`timescale 1ns/1ps
module dcmd_decoder import dcmd_pkg::*; (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [AXI_AW-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [AXI_AW-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic externalInterfaceEnable,
   input wire logic subsystemB,
   input wire logic reqValid,
   input wire logic reqWrite,
   input wire logic [1:0] reqSpace,
   input wire logic [6:0] programPageExtension,
   input wire logic [15:0] reqAddr,
   output logic accValid,
   output logic accWrite,
   output logic [15:0] accAddr,
   output logic [1:0] accPage,
   output logic [2:0] accBlock,
   output dcmd_sel_t accSel,
   output logic accOwnedRemote,
   output logic accDropped
);
   logic [31:0] ctrlWord;
   logic [31:0] statusWord;
   dcmd_sel_t sel;
   logic [1:0] effPage;
   logic [2:0] block;
   logic isShared;
   logic remote;
   logic drop;
   typedef struct packed {
      logic xioMeta;
      logic xioSync;
      logic valid;
      logic write;
      logic [15:0] addr;
      logic [1:0] page;
      logic [2:0] block;
      dcmd_sel_t sel;
      logic remote;
      logic dropped;
      logic [7:0] dropCount;
   } dcmd_dec_t;
   dcmd_dec_t s_q, s_d;

   dcmd_axil u_regs (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .awaddr(awaddr),
      .awvalid(awvalid),
      .awready(awready),
      .wdata(wdata),
      .wstrb(wstrb),
      .wvalid(wvalid),
      .wready(wready),
      .bresp(bresp),
      .bvalid(bvalid),
      .bready(bready),
      .araddr(araddr),
      .arvalid(arvalid),
      .arready(arready),
      .rdata(rdata),
      .rresp(rresp),
      .rvalid(rvalid),
      .rready(rready),
      .statusWord(statusWord),
      .ctrlWord(ctrlWord)
   );

   // Mode bits come from software, page and address from the core
   dcmd_route u_route (
      .space(reqSpace),
      .page(programPageExtension),
      .addr(reqAddr),
      .overlayEnable(ctrlWord[CTRL_OVERLAY_ENABLE]),
      .dataSramEnable(ctrlWord[CTRL_DSRAM]),
      .bootRomEnable(ctrlWord[CTRL_BOOT_ROM_ENABLE]),
      .microprocessorMode(ctrlWord[CTRL_MPMODE]),
      .sel(sel),
      .effPage(effPage),
      .block(block)
   );

   always_comb begin
      // Shared block owner differs from requester
      isShared = sel.shared0 | sel.shared1 | sel.shared2 | sel.shared3;
      remote = isShared &
         (subsystemB ? (sel.shared0 | sel.shared1)
                     : (sel.shared2 | sel.shared3));
      // Sampled enable, so the pin is never read raw
      drop = sel.ext & !s_q.xioSync;
      s_d = s_q;
      s_d.xioMeta = externalInterfaceEnable;
      s_d.xioSync = s_q.xioMeta;
      s_d.valid = reqValid;
      s_d.write = reqValid & reqWrite & !drop & !sel.resv;
      s_d.addr = reqAddr;
      s_d.page = effPage;
      s_d.block = block;
      s_d.sel = reqValid ? sel : '0;
      s_d.remote = reqValid & remote;
      s_d.dropped = reqValid & drop;
      if (reqValid && drop && s_q.dropCount != 8'hFF) begin
         s_d.dropCount = s_q.dropCount + 8'h01;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   // Status: synced enable, saturating count of refused external accesses
   assign statusWord = {16'h0000, s_q.dropCount, 7'h00, s_q.xioSync};
   assign accValid = s_q.valid;
   assign accWrite = s_q.write;
   assign accAddr = s_q.addr;
   assign accPage = s_q.page;
   assign accBlock = s_q.block;
   assign accSel = s_q.sel;
   assign accOwnedRemote = s_q.remote;
   assign accDropped = s_q.dropped;
endmodule

// *** verilog/dcmd_pkg.sv ***
// Constants and types shared by the memory map decoder
package dcmd_pkg;
   localparam logic [15:0] RESV_LAST = 16'h005F;
   localparam logic [15:0] LOCAL_LAST = 16'h7FFF;
   localparam logic [15:0] UPPER_FIRST = 16'h8000;
   localparam logic [15:0] SH0_LAST = 16'hDFFF;
   localparam logic [15:0] HOLE_FIRST = 16'hE000;
   localparam logic [15:0] ROM_FIRST = 16'hF800;
   localparam int BLOCK_LSB = 13;
   localparam logic [6:0] PAGE_LAST_INT = 7'h03;
   localparam logic [6:0] PAGE_LAST_EXT = 7'h07;
   localparam logic [1:0] PAGE_MASK = 2'h3;
   localparam int AXI_AW = 6;
   localparam logic [5:0] REG_CTRL = 6'h00;
   localparam logic [5:0] REG_STAT = 6'h04;
   localparam int CTRL_OVERLAY_ENABLE = 0;
   localparam int CTRL_DSRAM = 1;
   localparam int CTRL_MPMODE = 2;
   localparam int CTRL_BOOT_ROM_ENABLE = 7;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0080;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;
   typedef enum {
      DCMD_SPACE_PROG, DCMD_SPACE_DATA, DCMD_SPACE_IO
   } dcmd_space_t;
   // One-hot target select
   typedef struct packed {
      logic dual;
      logic single;
      logic shared0;
      logic shared1;
      logic shared2;
      logic shared3;
      logic rom;
      logic resv;
      logic ext;
   } dcmd_sel_t;
endpackage

// *** verilog/dcmd_route.sv ***
// Combinational address-to-target routing for one core access
`timescale 1ns/1ps
module dcmd_route import dcmd_pkg::*; (
   input wire logic [1:0] space,
   input wire logic [6:0] page,
   input wire logic [15:0] addr,
   input wire logic overlayEnable,
   input wire logic dataSramEnable,
   input wire logic bootRomEnable,
   input wire logic microprocessorMode,
   output dcmd_sel_t sel,
   output logic [1:0] effPage,
   output logic [2:0] block
);
   logic [6:0] aliasPage;
   always_comb begin
      sel = '0;
      aliasPage = page;
      // Block index inside an 8K-granular region
      block = addr[BLOCK_LSB+2:BLOCK_LSB];
      if (space == 2'(DCMD_SPACE_IO)) begin
         sel.ext = 1'b1;
      end else if (space == 2'(DCMD_SPACE_DATA)) begin
         if (addr < UPPER_FIRST) begin
            sel.dual = 1'b1;
         end else if (dataSramEnable) begin
            sel.single = 1'b1;
         end else begin
            sel.ext = 1'b1;
         end
      end else begin
         if (microprocessorMode) begin
            aliasPage = {5'h00, page[1:0] & PAGE_MASK};
         end else if (page > PAGE_LAST_EXT) begin
            aliasPage = {5'h01, page[1:0]};
         end
         if (addr <= RESV_LAST) begin
            sel.resv = 1'b1;
         end else if (addr <= LOCAL_LAST) begin
            if (overlayEnable) begin
               sel.dual = 1'b1;
            end else begin
               sel.ext = 1'b1;
            end
         end else if (microprocessorMode || aliasPage > PAGE_LAST_INT) begin
            sel.ext = 1'b1;
         end else begin
            case (aliasPage[1:0])
               2'h0: begin
                  if (addr <= SH0_LAST) begin
                     sel.shared0 = 1'b1;
                  end else if (!bootRomEnable) begin
                     sel.shared0 = 1'b1;
                  end else if (addr >= ROM_FIRST) begin
                     sel.rom = 1'b1;
                  end else begin
                     sel.resv = 1'b1;
                  end
               end
               2'h1: sel.shared1 = 1'b1;
               2'h2: sel.shared2 = 1'b1;
               2'h3: sel.shared3 = 1'b1;
               default: sel.ext = 1'b1;
            endcase
         end
      end
      effPage = aliasPage[1:0];
   end
endmodule

// *** verilog/dcmd_axil.sv ***
// AXI4-Lite slave holding the decoder mode bits
`timescale 1ns/1ps
module dcmd_axil import dcmd_pkg::*; (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [AXI_AW-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [AXI_AW-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic [31:0] statusWord,
   output logic [31:0] ctrlWord
);
   typedef struct packed {
      logic awHave;
      logic [AXI_AW-1:0] awAddr;
      logic wHave;
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic bValid;
      logic [1:0] bResp;
      logic rValid;
      logic [31:0] rData;
      logic [1:0] rResp;
      logic [31:0] ctrl;
      logic awRdy;
      logic wRdy;
      logic arRdy;
   } dcmd_axil_t;
   dcmd_axil_t s_q, s_d;
   always_comb begin
      s_d = s_q;
      if (awvalid && !s_q.awHave) begin
         s_d.awHave = 1'b1;
         s_d.awAddr = awaddr;
      end
      if (wvalid && !s_q.wHave) begin
         s_d.wHave = 1'b1;
         s_d.wData = wdata;
         s_d.wStrb = wstrb;
      end
      if (s_q.bValid && bready) begin
         s_d.bValid = 1'b0;
      end
      if (s_q.awHave && s_q.wHave && !s_q.bValid) begin
         s_d.awHave = 1'b0;
         s_d.wHave = 1'b0;
         s_d.bValid = 1'b1;
         s_d.bResp = RESP_OKAY;
         if (s_q.awAddr[AXI_AW-1:2] == REG_CTRL[AXI_AW-1:2]) begin
            for (int i = 0; i < 4; i++) begin
               if (s_q.wStrb[i]) begin
                  s_d.ctrl[i*8 +: 8] = s_q.wData[i*8 +: 8];
               end
            end
         end else if (s_q.awAddr[AXI_AW-1:2] != REG_STAT[AXI_AW-1:2]) begin
            s_d.bResp = RESP_DECERR;
         end
      end
      if (s_q.rValid && rready) begin
         s_d.rValid = 1'b0;
      end
      if (arvalid && !s_q.rValid) begin
         s_d.rValid = 1'b1;
         s_d.rResp = RESP_OKAY;
         if (araddr[AXI_AW-1:2] == REG_CTRL[AXI_AW-1:2]) begin
            s_d.rData = s_q.ctrl;
         end else if (araddr[AXI_AW-1:2] == REG_STAT[AXI_AW-1:2]) begin
            s_d.rData = statusWord;
         end else begin
            s_d.rData = 32'h0000_0000;
            s_d.rResp = RESP_DECERR;
         end
      end
      // Only mode bits exist; the rest stay zero
      s_d.ctrl = s_d.ctrl & 32'h0000_0087;
      // Ready kept in its own flop so no gate sits behind the port
      s_d.awRdy = !s_d.awHave;
      s_d.wRdy = !s_d.wHave;
      s_d.arRdy = !s_d.rValid;
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
         s_q.ctrl <= CTRL_RESET;
         s_q.awRdy <= 1'b1;
         s_q.wRdy <= 1'b1;
         s_q.arRdy <= 1'b1;
      end else if (ce) begin
         s_q <= s_d;
      end
   end
   assign awready = s_q.awRdy;
   assign wready = s_q.wRdy;
   assign bvalid = s_q.bValid;
   assign bresp = s_q.bResp;
   assign arready = s_q.arRdy;
   assign rvalid = s_q.rValid;
   assign rdata = s_q.rData;
   assign rresp = s_q.rResp;
   assign ctrlWord = s_q.ctrl;
endmodule

// *** verification/dcmd_core_model.sv ***
// Core-side access source standing in for the subsystem CPU
`timescale 1ns/1ps
module dcmd_core_model (
   input wire logic clk,
   output logic reqValid,
   output logic reqWrite,
   output logic [1:0] reqSpace,
   output logic [6:0] programPageExtension,
   output logic [15:0] reqAddr
);
   initial begin
      reqValid = 1'h0;
      reqWrite = 1'h0;
      reqSpace = 2'h0;
      programPageExtension = 7'h00;
      reqAddr = 16'h0000;
   end
   // One access per call; released write and address lines are inverted, space and page are left stale
   task automatic issue(input logic [1:0] sp, input logic [6:0] pg,
         input logic [15:0] ad, input logic wr);
      @(posedge clk);
      reqValid <= 1'h1;
      reqWrite <= wr;
      reqSpace <= sp;
      programPageExtension <= pg;
      reqAddr <= ad;
      @(posedge clk);
      reqValid <= 1'h0;
      reqWrite <= ~wr;
      reqAddr <= ~ad;
   endtask
endmodule

// *** verification/dcmd_decoder_asserts.sv ***
// Concurrent checks on the decoder's core-side ports
`timescale 1ns/1ps
module dcmd_decoder_asserts import dcmd_pkg::*; (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic externalInterfaceEnable,
   input wire logic reqValid,
   input wire logic reqWrite,
   input wire logic [1:0] reqSpace,
   input wire logic [6:0] programPageExtension,
   input wire logic [15:0] reqAddr,
   input wire logic accValid,
   input wire logic accWrite,
   input wire logic [15:0] accAddr,
   input wire logic [1:0] accPage,
   input wire logic [2:0] accBlock,
   input wire dcmd_sel_t accSel,
   input wire logic accDropped
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   logic take;
   assign take = reqValid && ce;
   AST_ONE_TARGET:
      assert property (accValid |-> $onehot(accSel))
      else $error("not exactly one target");
   AST_ANSWER_NEXT:
      assert property (take |=> accValid && accAddr == $past(reqAddr))
      else $error("access not answered next cycle");
   AST_IO_EXTERNAL:
      assert property (take && reqSpace == 2'h2 |=> accSel.ext)
      else $error("I/O access not external");
   AST_PAGE_ALIAS:
      assert property (take && reqSpace == 2'h0
         |=> accPage == $past(programPageExtension[1:0]))
      else $error("page alias wrong");
   AST_BLOCK_INDEX:
      assert property (take |=> accBlock == $past(reqAddr[15:13]))
      else $error("block index wrong");
   AST_RESERVED_LOW:
      assert property (take && reqSpace == 2'h0 && reqAddr <= RESV_LAST
         |=> accSel.resv && !accWrite)
      else $error("low program area not reserved");
   AST_DROP_SILENT:
      assert property (accDropped |-> accSel.ext && !accWrite)
      else $error("dropped access still writes");
   AST_XIO_LOW:
      assert property ((!externalInterfaceEnable)[*6] ##0 accSel.ext
         |-> accDropped)
      else $error("external access not dropped");
   AST_XIO_HIGH:
      assert property (externalInterfaceEnable[*6] ##0 accSel.ext
         |-> !accDropped)
      else $error("external access dropped while enabled");
   AST_DATA_LOW:
      assert property (take && reqWrite && reqSpace == 2'h1
         && reqAddr < UPPER_FIRST |=> accSel.dual && accWrite)
      else $error("low data write not to local RAM");
endmodule
bind dcmd_decoder dcmd_decoder_asserts u_asserts (.clk, .rst, .ce,
   .externalInterfaceEnable, .reqValid, .reqWrite, .reqSpace,
   .programPageExtension, .reqAddr, .accValid, .accWrite, .accAddr,
   .accPage, .accBlock, .accSel, .accDropped);

// *** verification/dcmd_decoder_tb_top.sv ***
// Self-checking bench for the memory map decoder
`timescale 1ns/1ps
module dcmd_decoder_tb_top import dcmd_pkg::*; ;
   logic clk, rst, ce, awvalid, wvalid, bready, arvalid, rready;
   logic externalInterfaceEnable, subsystemB, reqValid, reqWrite;
   logic awready, wready, bvalid, arready, rvalid, accValid, accWrite;
   logic accOwnedRemote, accDropped;
   logic [5:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, accPage, reqSpace;
   logic [6:0] programPageExtension;
   logic [15:0] reqAddr, accAddr;
   logic [2:0] accBlock;
   dcmd_sel_t accSel;
   int failures = 0;
   int checkCount = 0;
   dcmd_decoder u_dut (.clk, .rst, .ce, .awaddr, .awvalid, .awready,
      .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
      .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
      .externalInterfaceEnable, .subsystemB, .reqValid, .reqWrite,
      .reqSpace, .programPageExtension, .reqAddr, .accValid, .accWrite,
      .accAddr, .accPage, .accBlock, .accSel, .accOwnedRemote, .accDropped);
   dcmd_core_model u_core (.clk, .reqValid, .reqWrite, .reqSpace,
      .programPageExtension, .reqAddr);
   initial begin
      clk = 1'h0;
      forever #2.5 clk = ~clk;
   end
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checkCount, failures);
      if (failures == 0 && checkCount > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checkCount++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
      end while (!bvalid);
      bready <= 1'h0;
      chk(32'(bresp), 32'(RESP_OKAY));
   endtask
   task automatic rd(input logic [5:0] a, input logic [31:0] d,
         input logic [1:0] r);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 1'h0;
      end while (!rvalid);
      rready <= 1'h0;
      chk(rdata, d);
      chk(32'(rresp), 32'(r));
   endtask
   task automatic mode(input logic [31:0] c);
      wr(REG_CTRL, c);
      rd(REG_CTRL, c, RESP_OKAY);
   endtask
   // Expected remote ownership is derived from the expected target and subsystemB, page low bits from the requested page, then compared with the outputs
   task automatic ac(input logic [1:0] sp, input logic [6:0] pg,
         input logic [15:0] ad, input logic w, input logic [8:0] sel);
      logic dr, rm;
      dr = (sel == 9'h001) && !externalInterfaceEnable;
      rm = subsystemB ? |sel[6:5] : |sel[4:3];
      u_core.issue(sp, pg, ad, w);
      #1;
      chk(32'({accValid, accSel, sp == 2'h0 ? accPage : 2'h0,
         accOwnedRemote, accDropped, accWrite}),
         32'({1'h1, sel, sp == 2'h0 ? pg[1:0] : 2'h0, rm, dr,
         w && !dr && sel != 9'h002}));
   endtask
   task automatic t_map();
      ac(2'h0, 7'h00, 16'hF800, 1'h0, 9'h004);
      ac(2'h0, 7'h00, 16'hFFFF, 1'h0, 9'h004);
      ac(2'h0, 7'h00, 16'h005F, 1'h1, 9'h002);
      ac(2'h0, 7'h00, 16'hE000, 1'h0, 9'h002);
      ac(2'h0, 7'h00, 16'hF7FF, 1'h0, 9'h002);
      ac(2'h0, 7'h00, 16'h0060, 1'h0, 9'h001);
      ac(2'h0, 7'h01, 16'h7FFF, 1'h0, 9'h001);
      ac(2'h0, 7'h00, 16'hDFFF, 1'h0, 9'h040);
      ac(2'h0, 7'h01, 16'h8000, 1'h0, 9'h020);
      ac(2'h0, 7'h02, 16'hA000, 1'h0, 9'h010);
      ac(2'h0, 7'h03, 16'hFFFF, 1'h0, 9'h008);
      ac(2'h0, 7'h04, 16'h8000, 1'h0, 9'h001);
      ac(2'h0, 7'h09, 16'hC000, 1'h0, 9'h001);
      ac(2'h0, 7'h7F, 16'h9000, 1'h0, 9'h001);
      ac(2'h1, 7'h00, 16'h8000, 1'h0, 9'h001);
      ac(2'h1, 7'h00, 16'h1000, 1'h1, 9'h100);
      ac(2'h2, 7'h00, 16'h1234, 1'h1, 9'h001);
      $display("t_map done");
   endtask
   task automatic t_modes();
      mode(32'h0000_0083);
      ac(2'h0, 7'h02, 16'h0060, 1'h0, 9'h100);
      ac(2'h1, 7'h00, 16'h9000, 1'h1, 9'h080);
      mode(32'h0000_0000);
      ac(2'h0, 7'h00, 16'hE000, 1'h0, 9'h040);
      ac(2'h0, 7'h00, 16'hFFFF, 1'h0, 9'h040);
      mode(32'h0000_0085);
      ac(2'h0, 7'h00, 16'hF800, 1'h0, 9'h001);
      ac(2'h0, 7'h05, 16'h8000, 1'h0, 9'h001);
      ac(2'h0, 7'h06, 16'h0100, 1'h0, 9'h100);
      $display("t_modes done");
   endtask
   task automatic t_xio();
      @(posedge clk);
      externalInterfaceEnable <= 1'h0;
      repeat (6) @(posedge clk);
      ac(2'h2, 7'h00, 16'h0042, 1'h1, 9'h001);
      ac(2'h0, 7'h00, 16'h9000, 1'h0, 9'h001);
      ac(2'h1, 7'h00, 16'h0200, 1'h1, 9'h100);
      @(posedge clk);
      externalInterfaceEnable <= 1'h1;
      subsystemB <= 1'h1;
      mode(32'h0000_0080);
      // Two refused external accesses counted, enable seen high again
      rd(REG_STAT, 32'h0000_0201, RESP_OKAY);
      ac(2'h0, 7'h00, 16'h8000, 1'h0, 9'h040);
      ac(2'h0, 7'h02, 16'h8000, 1'h0, 9'h010);
      ac(2'h2, 7'h00, 16'hFFFF, 1'h1, 9'h001);
      $display("t_xio done");
   endtask
   // A request offered while the clock enable is low must not appear
   task automatic t_freeze();
      @(posedge clk);
      ce <= 1'h0;
      u_core.issue(2'h2, 7'h00, 16'h0001, 1'h1);
      #1;
      chk(32'(accValid), 32'h0000_0000);
      @(posedge clk);
      ce <= 1'h1;
      $display("t_freeze done");
   endtask
   initial begin
      #100000;
      failures++;
      $display("[ERR] %0t watchdog expired", $time);
      end_sim();
   end
   initial begin
      {rst, ce, externalInterfaceEnable} = 3'h7;
      {awvalid, wvalid, bready, arvalid, rready, subsystemB} = 6'h00;
      {awaddr, araddr, wdata, wstrb} = 48'h0000_0000_000F;
      repeat (4) @(posedge clk);
      rst <= 1'h0;
      rd(REG_CTRL, CTRL_RESET, RESP_OKAY);
      rd(6'h08, 32'h0000_0000, RESP_DECERR);
      t_map();
      t_modes();
      t_xio();
      t_freeze();
      end_sim();
   end
endmodule
